// ==== swc_pkg.sv ====
package swc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] CLKCFG_OFF = 8'h04;
    localparam logic [7:0] WAKEEN_OFF = 8'h08;
    localparam logic [7:0] STAT_OFF   = 8'h0C;
    localparam logic [7:0] MASK_OFF   = 8'h10;
    localparam logic [7:0] STATE_OFF  = 8'h14;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned RUN_BIT     = 0;
    localparam int unsigned SUSP_BIT    = 3;
    localparam logic [7:0]  ENTER_VALUE = 8'h09;
    localparam logic        RUN_RST     = 1'b1;
    localparam int unsigned EXT_BIT     = 0;
    localparam int unsigned ADJ_LSB     = 4;
    localparam int unsigned ADJ_W       = 3;
    localparam int unsigned DLY_BIT     = 7;
    localparam logic [7:0]  CLKCFG_RST  = 8'h00;
    localparam int unsigned WT_EN_BIT   = 0;
    localparam int unsigned GPIO_EN_BIT = 1;
    localparam logic [1:0]  WAKEEN_RST  = 2'h0;
    localparam int unsigned ST_W        = 4;
    localparam int unsigned ST_WT       = 0;
    localparam int unsigned ST_GPIO     = 1;
    localparam int unsigned ST_USB      = 2;
    localparam int unsigned ST_RES      = 3;
    localparam logic [3:0]  STAT_RST    = 4'h0;
    localparam logic [3:0]  MASK_RST    = 4'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_NS     = 4;
    localparam int unsigned T_INT_NS   = 8000;
    localparam int unsigned T_EXTS_NS  = 128000;
    localparam int unsigned T_EXTL_NS  = 4000000;
    localparam int unsigned T_WAKE_NS  = 1000000;
    localparam int unsigned INT_CYC    = (T_INT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned EXTS_CYC   = (T_EXTS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned EXTL_CYC   = (T_EXTL_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WAKE_CYC   = T_WAKE_NS / CLK_NS;

    typedef enum logic [5:0] {
        ST_RUN_INT  = 6'h01,
        ST_RUN_EXT  = 6'h02,
        ST_SUSP     = 6'h04,
        ST_WAKE_INT = 6'h08,
        ST_OSC_WAIT = 6'h10,
        ST_EXT_DLY  = 6'h20
    } swc_state_e;

endpackage : swc_pkg

// ==== swc_suspend_wake_controller.sv ====
`timescale 1ns/1ps
module swc_suspend_wake_controller #(
    parameter int unsigned EXT_SHORT_CYC = swc_pkg::EXTS_CYC,
    parameter int unsigned EXT_LONG_CYC  = swc_pkg::EXTL_CYC,
    parameter int unsigned WAKE_BASE_CYC = swc_pkg::WAKE_CYC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // wake sources and oscillator monitor, asynchronous
    input  wire logic        gpio_irq_in,
    input  wire logic        usb_minus_serial_data_pin,
    input  wire logic        ext_osc_stable,
    // processor handshake
    input  wire logic        cpu_insn_done,
    // power and clock control
    output logic             cpu_run,
    output logic             int_osc_en,
    output logic             ext_osc_en,
    output logic             clk_ext_sel,
    output logic             timers_en,
    output logic             suspended,
    output logic             irq_defer,
    output logic             irq
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       gpio_d1_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q   <= 3'h2;
            sync2_q   <= 3'h2;
            gpio_d1_q <= 1'b0;
        end
        else
        begin
            sync1_q   <= {ext_osc_stable, usb_minus_serial_data_pin, gpio_irq_in};
            sync2_q   <= sync1_q;
            gpio_d1_q <= sync2_q[0];
        end
    end

    wire gpio_s   = sync2_q[0];
    wire dm_low   = !sync2_q[1];
    wire stable_s = sync2_q[2];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic                   pready_q;
    logic                   pslverr_q;
    logic [31:0]            prdata_q;
    logic                   run_q;
    logic [7:0]             clkcfg_q;
    logic [1:0]             wakeen_q;
    logic [swc_pkg::ST_W-1:0] stat_q;
    logic [swc_pkg::ST_W-1:0] mask_q;
    logic                   ext_mode_q;
    swc_pkg::swc_state_e    state_q;
    swc_pkg::swc_state_e    state_d;

    wire acc_first = psel && penable && !pready_q;
    wire acc_done  = psel && penable && pready_q;
    wire hit_ctrl  = paddr == swc_pkg::CTRL_OFF;
    wire hit_clk   = paddr == swc_pkg::CLKCFG_OFF;
    wire hit_wen   = paddr == swc_pkg::WAKEEN_OFF;
    wire hit_stat  = paddr == swc_pkg::STAT_OFF;
    wire hit_mask  = paddr == swc_pkg::MASK_OFF;
    wire hit_state = paddr == swc_pkg::STATE_OFF;
    wire hit_any   = hit_ctrl | hit_clk | hit_wen | hit_stat | hit_mask | hit_state;
    wire wr_en     = acc_done && pwrite;
    wire running   = state_q == swc_pkg::ST_RUN_INT || state_q == swc_pkg::ST_RUN_EXT;
    wire susp_wr   = wr_en && hit_ctrl && pwdata[swc_pkg::SUSP_BIT] && running;

    wire [31:0] rd_ctrl  = {28'h0, state_q == swc_pkg::ST_SUSP, 2'h0, run_q};
    wire [31:0] rd_state = {23'h0, ext_mode_q, 2'h0, state_q};
    wire [31:0] rd_mux   = hit_ctrl  ? rd_ctrl :
                           hit_clk   ? {24'h0, clkcfg_q} :
                           hit_wen   ? {30'h0, wakeen_q} :
                           hit_stat  ? {28'h0, stat_q} :
                           hit_mask  ? {28'h0, mask_q} :
                           hit_state ? rd_state : 32'h0;

    // one wait state: data and error are captured in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end
        else
        begin
            pready_q  <= acc_first;
            pslverr_q <= acc_first && !hit_any;
            prdata_q  <= (acc_first && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // wake-up timer
    // ------------------------------------------------------------
    function automatic logic [31:0] wt_period(input logic [swc_pkg::ADJ_W-1:0] adj);
        wt_period = WAKE_BASE_CYC[31:0] << adj;
    endfunction : wt_period

    logic [31:0] wt_cnt_q;
    wire         wt_en   = wakeen_q[swc_pkg::WT_EN_BIT];
    wire [2:0]   wt_adj  = clkcfg_q[swc_pkg::ADJ_LSB +: swc_pkg::ADJ_W];
    wire         wt_fire = wt_en && (wt_cnt_q >= wt_period(wt_adj) - 32'h1);

    // the timer ignores suspend and global enables on purpose, so it can poll from sleep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wt_cnt_q <= 32'h0;
        else if (!wt_en || wt_fire)
            wt_cnt_q <= 32'h0;
        else
            wt_cnt_q <= wt_cnt_q + 32'h1;
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    wire gpio_wake = gpio_s && wakeen_q[swc_pkg::GPIO_EN_BIT];
    wire in_susp   = state_q == swc_pkg::ST_SUSP;
    wire wake_any  = wt_fire || gpio_wake || dm_low;
    wire resume_go = (state_q == swc_pkg::ST_WAKE_INT || state_q == swc_pkg::ST_EXT_DLY)
                     && (state_d == swc_pkg::ST_RUN_INT || state_d == swc_pkg::ST_RUN_EXT);
    logic wake_path_q;

    wire [3:0] st_set = {resume_go && wake_path_q, in_susp && dm_low,
                         gpio_s && !gpio_d1_q, wt_fire};
    wire [3:0] st_clr = (wr_en && hit_stat) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q    <= swc_pkg::RUN_RST;
            clkcfg_q <= swc_pkg::CLKCFG_RST;
            wakeen_q <= swc_pkg::WAKEEN_RST;
            stat_q   <= swc_pkg::STAT_RST;
            mask_q   <= swc_pkg::MASK_RST;
        end
        else
        begin
            if (wr_en && hit_ctrl)
                run_q <= pwdata[swc_pkg::RUN_BIT];
            if (wr_en && hit_clk)
                clkcfg_q <= pwdata[7:0];
            if (wr_en && hit_wen)
                wakeen_q <= pwdata[1:0];
            if (wr_en && hit_mask)
                mask_q <= pwdata[3:0];
            stat_q <= (stat_q & ~st_clr) | st_set;
        end
    end

    // ------------------------------------------------------------
    // power sequencer
    // ------------------------------------------------------------
    logic [31:0] dly_q;
    logic        osc_low_q;
    wire  [31:0] ext_dly = clkcfg_q[swc_pkg::DLY_BIT] ? EXT_LONG_CYC[31:0]
                                                      : EXT_SHORT_CYC[31:0];

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            swc_pkg::ST_RUN_INT:
                if (susp_wr)
                    state_d = swc_pkg::ST_SUSP;
                else if (clkcfg_q[swc_pkg::EXT_BIT])
                    state_d = swc_pkg::ST_OSC_WAIT;
            swc_pkg::ST_RUN_EXT:
                if (susp_wr)
                    state_d = swc_pkg::ST_SUSP;
            swc_pkg::ST_SUSP:
                if (run_q && wake_any)
                    state_d = ext_mode_q ? swc_pkg::ST_OSC_WAIT
                                         : swc_pkg::ST_WAKE_INT;
            swc_pkg::ST_WAKE_INT:
                if (dly_q == 32'h0)
                    state_d = swc_pkg::ST_RUN_INT;
            swc_pkg::ST_OSC_WAIT:
                // a monitor level left over from before suspend is stale: wait for it to drop
                if (stable_s && osc_low_q)
                    state_d = swc_pkg::ST_EXT_DLY;
            swc_pkg::ST_EXT_DLY:
                if (dly_q == 32'h0)
                    state_d = swc_pkg::ST_RUN_EXT;
            default:
                state_d = swc_pkg::ST_RUN_INT;
        endcase
    end

    wire enter_int = state_d == swc_pkg::ST_WAKE_INT && state_q != swc_pkg::ST_WAKE_INT;
    wire enter_ext = state_d == swc_pkg::ST_EXT_DLY && state_q != swc_pkg::ST_EXT_DLY;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q     <= swc_pkg::ST_RUN_INT;
            dly_q       <= 32'h0;
            ext_mode_q  <= 1'b0;
            wake_path_q <= 1'b0;
            osc_low_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (enter_int)
                dly_q <= swc_pkg::INT_CYC[31:0] - 32'h1;
            else if (enter_ext)
                dly_q <= ext_dly - 32'h1;
            else if (dly_q != 32'h0)
                dly_q <= dly_q - 32'h1;
            if (susp_wr)
                ext_mode_q <= clkcfg_q[swc_pkg::EXT_BIT];
            if (in_susp && state_d != swc_pkg::ST_SUSP)
                wake_path_q <= 1'b1;
            else if (resume_go)
                wake_path_q <= 1'b0;
            if (state_q != swc_pkg::ST_OSC_WAIT)
                osc_low_q <= 1'b0;
            else if (!stable_s)
                osc_low_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic cpu_run_q;
    logic int_osc_q;
    logic ext_osc_q;
    logic ext_sel_q;
    logic timers_q;
    logic susp_q;
    logic defer_q;
    logic irq_q;

    wire run_d  = state_d == swc_pkg::ST_RUN_INT || state_d == swc_pkg::ST_RUN_EXT;
    wire ext_on = state_d == swc_pkg::ST_OSC_WAIT || state_d == swc_pkg::ST_EXT_DLY
                  || state_d == swc_pkg::ST_RUN_EXT;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_run_q <= 1'b1;
            int_osc_q <= 1'b1;
            ext_osc_q <= 1'b0;
            ext_sel_q <= 1'b0;
            timers_q  <= 1'b1;
            susp_q    <= 1'b0;
            defer_q   <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            cpu_run_q <= run_d;
            int_osc_q <= state_d == swc_pkg::ST_RUN_INT || state_d == swc_pkg::ST_WAKE_INT;
            ext_osc_q <= ext_on;
            ext_sel_q <= state_d == swc_pkg::ST_EXT_DLY || state_d == swc_pkg::ST_RUN_EXT;
            timers_q  <= state_d != swc_pkg::ST_SUSP;
            susp_q    <= state_d == swc_pkg::ST_SUSP;
            // one instruction must retire first, else an isr would run ahead of it
            if (resume_go && wake_path_q)
                defer_q <= 1'b1;
            else if (cpu_insn_done)
                defer_q <= 1'b0;
            irq_q <= |(stat_q & mask_q) && !defer_q;
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign cpu_run     = cpu_run_q;
    assign int_osc_en  = int_osc_q;
    assign ext_osc_en  = ext_osc_q;
    assign clk_ext_sel = ext_sel_q;
    assign timers_en   = timers_q;
    assign suspended   = susp_q;
    assign irq_defer   = defer_q;
    assign irq         = irq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    int unsigned int_cnt_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_cnt_q <= 0;
        else if (state_q == swc_pkg::ST_WAKE_INT)
            int_cnt_q <= int_cnt_q + 1;
        else
            int_cnt_q <= 0;
    end

    sequence wake_from_susp;
        in_susp ##1 !in_susp;
    endsequence

    sequence resume_seen;
        resume_go && wake_path_q;
    endsequence

    suspend_entry_a : assert property (susp_wr |=> in_susp && suspended)
        else $error("suspend write did not suspend");
    susp_clocks_a : assert property (in_susp ##1 in_susp |->
        !int_osc_en && !ext_osc_en && !timers_en && !cpu_run)
        else $error("clocks alive in suspend");
    wake_source_a : assert property (wake_from_susp |-> $past(wake_any))
        else $error("wake without source");
    run_gate_a : assert property (in_susp && !run_q |=> in_susp)
        else $error("resumed without run bit");
    int_delay_a : assert property (state_q == swc_pkg::ST_WAKE_INT
        && state_d == swc_pkg::ST_RUN_INT |-> int_cnt_q == swc_pkg::INT_CYC - 1)
        else $error("internal wake delay wrong");
    osc_hold_a : assert property (state_q == swc_pkg::ST_OSC_WAIT && !stable_s
        |=> !cpu_run && state_q == swc_pkg::ST_OSC_WAIT)
        else $error("left oscillator wait early");
    ext_lock_a : assert property (state_q == swc_pkg::ST_RUN_EXT && !susp_wr
        |=> state_q == swc_pkg::ST_RUN_EXT)
        else $error("left external mode without suspend");
    mode_pick_a : assert property (wake_from_susp |->
        (state_q == swc_pkg::ST_OSC_WAIT) == ext_mode_q)
        else $error("wrong wake clock mode");
    timer_reset_a : assert property (!wt_en |=> wt_cnt_q == 32'h0)
        else $error("wake timer not reset");
    timer_period_a : assert property (wt_fire |=> wt_cnt_q == 32'h0
        ##1 (!wt_en || wt_cnt_q == 32'h1))
        else $error("wake timer did not restart");
    defer_hold_a : assert property (resume_seen ##1 !cpu_insn_done |=> irq_defer && !irq)
        else $error("interrupt not deferred");
    ext_delay_a : assert property ($rose(state_q == swc_pkg::ST_EXT_DLY) |->
        dly_q == ext_dly - 32'h1)
        else $error("external resume delay wrong");

endmodule : swc_suspend_wake_controller

// ==== swc_wake_partner.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// oscillator monitor and processor stand-in
// ------------------------------------------------------------
module swc_wake_partner #(
    parameter int unsigned STABLE_CYC = 30
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // from the block
    input  wire logic ext_osc_en,
    input  wire logic cpu_run,
    // to the block
    output logic      ext_osc_stable,
    output logic      cpu_insn_done
);
    int unsigned warm_q;

    // the resonator needs time to settle and loses lock as soon as it is switched off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            warm_q         <= 0;
            ext_osc_stable <= 1'b0;
            cpu_insn_done  <= 1'b0;
        end
        else
        begin
            warm_q         <= ext_osc_en ? warm_q + 1 : 0;
            ext_osc_stable <= ext_osc_en && (warm_q >= STABLE_CYC);
            // slow core: one instruction retires every other running cycle
            cpu_insn_done  <= cpu_run && !cpu_insn_done;
        end
    end
endmodule : swc_wake_partner

// ==== test_suspend_wake_controller.sv ====
`timescale 1ns/1ps
module test_suspend_wake_controller;
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [31:0] pwdata      = 32'h0;
    logic        gpio_irq_in = 1'b0;
    logic        usb_pin     = 1'b1;
    logic [31:0] prdata;
    logic        pready, pslverr, ext_osc_stable, cpu_insn_done;
    logic        cpu_run, int_osc_en, ext_osc_en, clk_ext_sel;
    logic        timers_en, suspended, irq_defer, irq;
    logic [32:0] exp_q[$];
    int          miscompares = 0;
    int          tests_run   = 0;
    int          cyc         = 0;
    int          t0;

    always #2 pclk = ~pclk;

    swc_suspend_wake_controller #(
        .EXT_SHORT_CYC(20),
        .EXT_LONG_CYC (40),
        .WAKE_BASE_CYC(16)
    ) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpio_irq_in(gpio_irq_in),
        .usb_minus_serial_data_pin(usb_pin), .ext_osc_stable(ext_osc_stable),
        .cpu_insn_done(cpu_insn_done), .cpu_run(cpu_run), .int_osc_en(int_osc_en),
        .ext_osc_en(ext_osc_en), .clk_ext_sel(clk_ext_sel), .timers_en(timers_en),
        .suspended(suspended), .irq_defer(irq_defer), .irq(irq)
    );

    swc_wake_partner #(.STABLE_CYC(30)) partner (
        .pclk(pclk), .presetn(presetn), .ext_osc_en(ext_osc_en), .cpu_run(cpu_run),
        .ext_osc_stable(ext_osc_stable), .cpu_insn_done(cpu_insn_done)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        tests_run++;
        if (seen !== want)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic final_report;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // cycle count moves by nonblocking update so readers never race it
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc > 40000)
        begin
            miscompares++;
            final_report();
        end
    end

    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, exp_q.pop_front());

    // ------------------------------------------------------------
    // bus and wait helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] want);
        if (!w)
            exp_q.push_back(want);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_sig(ref logic s, input logic v);
        while (s !== v)
            @(posedge pclk);
    endtask : wait_sig

    initial
    begin
        void'($urandom(24396));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, swc_pkg::CTRL_OFF, 0, 33'h1);
        apb(0, swc_pkg::CLKCFG_OFF, 0, 33'h0);
        apb(0, swc_pkg::WAKEEN_OFF, 0, 33'h0);
        apb(0, swc_pkg::STAT_OFF, 0, 33'h0);
        apb(0, swc_pkg::MASK_OFF, 0, 33'h0);
        apb(0, 8'h18 + 8'(($urandom % 8) * 4), 0, 33'h1_0000_0000);
        $display("reset test done");
        // masked event still sets status, then periodic firing per adjust code
        apb(1, swc_pkg::WAKEEN_OFF, 32'h1, 0);
        repeat (40) @(posedge pclk);
        check(irq, 0);
        apb(0, swc_pkg::STAT_OFF, 0, 33'h1);
        apb(1, swc_pkg::MASK_OFF, 32'h1, 0);
        for (int a = 0; a < 8; a++)
        begin
            apb(1, swc_pkg::CLKCFG_OFF, 32'(a) << swc_pkg::ADJ_LSB, 0);
            wait_sig(irq, 1);
            apb(1, swc_pkg::STAT_OFF, 32'h1, 0);
            wait_sig(irq, 0);
            wait_sig(irq, 1);
            t0 = cyc;
            apb(1, swc_pkg::STAT_OFF, 32'h1, 0);
            wait_sig(irq, 0);
            wait_sig(irq, 1);
            check(33'(cyc - t0), 33'(16 << a));
        end
        apb(1, swc_pkg::CLKCFG_OFF, 0, 0);
        apb(1, swc_pkg::WAKEEN_OFF, 0, 0);
        apb(1, swc_pkg::STAT_OFF, 32'hF, 0);
        repeat (40) @(posedge pclk);
        check(irq, 0);
        $display("wake timer test done");
        // of the two switchable sources only gpio is left enabled; the usb d- source has no enable
        apb(1, swc_pkg::WAKEEN_OFF, 32'h2, 0);
        apb(1, swc_pkg::CTRL_OFF, 32'h09, 0);
        wait_sig(suspended, 1);
        check({int_osc_en, ext_osc_en, timers_en, cpu_run}, 0);
        repeat ($urandom % 50 + 5) @(posedge pclk);
        check(suspended, 1);
        gpio_irq_in <= 1'b1;
        t0 = cyc;
        wait_sig(cpu_run, 1);
        check(33'(cyc - t0 >= 2000 && cyc - t0 < 2010), 1);
        check({irq_defer, clk_ext_sel, int_osc_en}, 33'h5);
        wait_sig(irq_defer, 0);
        gpio_irq_in <= 1'b0;
        apb(0, swc_pkg::STATE_OFF, 0, 33'h001);
        apb(0, swc_pkg::STAT_OFF, 0, 33'hA);
        $display("internal wake test done");
        apb(1, swc_pkg::CLKCFG_OFF, 32'h01, 0);
        wait_sig(cpu_run, 0);
        t0 = cyc;
        wait_sig(cpu_run, 1);
        check(33'(cyc - t0 >= 50), 1);
        check({clk_ext_sel, int_osc_en}, 33'h2);
        apb(1, swc_pkg::CLKCFG_OFF, 32'h80, 0);
        apb(0, swc_pkg::STATE_OFF, 0, 33'h002);
        // wake cause already present at entry, long external delay
        apb(1, swc_pkg::CLKCFG_OFF, 32'h81, 0);
        usb_pin <= 1'b0;
        apb(1, swc_pkg::CTRL_OFF, 32'h09, 0);
        wait_sig(cpu_run, 0);
        t0 = cyc;
        wait_sig(cpu_run, 1);
        check(33'(cyc - t0 >= 70), 1);
        usb_pin <= 1'b1;
        apb(0, swc_pkg::STATE_OFF, 0, 33'h102);
        $display("external wake test done");
        // without the run bit no wake source can bring the core back
        apb(1, swc_pkg::CTRL_OFF, 32'h08, 0);
        wait_sig(suspended, 1);
        gpio_irq_in <= 1'b1;
        repeat (2100) @(posedge pclk);
        check({suspended, cpu_run}, 33'h2);
        presetn     <= 1'b0;
        gpio_irq_in <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({cpu_run, suspended}, 33'h2);
        $display("run bit test done");
        final_report();
    end
endmodule : test_suspend_wake_controller
